/* File: tx_fifo_params.svh */
/*
  Timing, depth and reset constants for the transmit phase FIFO and byte serializer.
  Assumes inclusion by the package, the design modules of this block and the bench only.
*/
`ifndef TX_FIFO_PARAMS_SVH
`define TX_FIFO_PARAMS_SVH

// ----------------------------------------------------------------
// Clock, depth, pointer and count widths, and latency figures
// ----------------------------------------------------------------
`define TX_CLK_PERIOD_NS  20
`define TX_FIFO_DEPTH     4
`define TX_FIFO_PTR_W     2
`define TX_FIFO_CNT_W     3
`define TX_LAT_MIN_CYC    2
`define TX_LAT_MAX_CYC    3
`define TX_REG_LAT_CYC    1

// ----------------------------------------------------------------
// Word width and width select codes
// ----------------------------------------------------------------
`define TX_WORD_W         20
`define TX_WSEL_8         2'h0
`define TX_WSEL_10        2'h1
`define TX_WSEL_16        2'h2
`define TX_WSEL_20        2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TX_RST_DATA       20'h00000
`define TX_RST_CNT        3'h0
`define TX_RST_PTR        2'h0

`endif

/* File: tx_fifo_pkg.sv */
/*
  Types shared by the transmit phase FIFO and the byte serializer.
  Assumes tx_fifo_params.svh is on the include path.
*/
`include "tx_fifo_params.svh"

package tx_fifo_pkg;
  // FIFO operating mode
  typedef enum logic {
    MODE_FIFO,
    MODE_REG
  } fifo_mode_t;

  // Serializer half being sent
  typedef enum logic {
    HALF_LOW,
    HALF_HIGH
  } ser_half_t;

  // Parallel word carrier
  typedef logic [`TX_WORD_W-1:0] word_t;
endpackage

/* File: byte_splitter.sv */
/*
  Byte serializer: sends each word as two half-width words, low half first,
  or passes words through whole when bypassed.
  Assumes one clock, a clock enable freezing all state, synchronous reset.
*/
`timescale 1ns/1ps
`include "tx_fifo_params.svh"

module byte_splitter
  import tx_fifo_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  // Configuration
  input  wire logic       ser_en,
  input  wire logic [1:0] width_sel,
  // Word in
  input  wire logic       in_valid,
  input  wire word_t      in_data,
  output logic            in_ready,
  // Word out
  output logic            out_valid,
  output word_t           out_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ser_half_t half;        // Which half goes next
  word_t     upper;       // Held upper half
  word_t     lo_part;     // Low half of the incoming word
  word_t     hi_part;     // High half of the incoming word

  // Accept a new word unless the upper half is still pending
  assign in_ready = (half == HALF_LOW);

  // Split by configured width, halves right aligned
  always_comb begin
    lo_part = `TX_RST_DATA;
    hi_part = `TX_RST_DATA;
    case (width_sel)
      `TX_WSEL_8: begin
        lo_part[3:0] = in_data[3:0];
        hi_part[3:0] = in_data[7:4];
      end
      `TX_WSEL_10: begin
        lo_part[4:0] = in_data[4:0];
        hi_part[4:0] = in_data[9:5];
      end
      `TX_WSEL_16: begin
        lo_part[7:0] = in_data[7:0];
        hi_part[7:0] = in_data[15:8];
      end
      default: begin
        lo_part[9:0] = in_data[9:0];
        hi_part[9:0] = in_data[19:10];
      end
    endcase
  end

  // Half sequencing and output register
  always_ff @(posedge clk) begin
    if (srst) begin
      half      <= HALF_LOW;
      upper     <= `TX_RST_DATA;
      out_valid <= 1'b0;
      out_data  <= `TX_RST_DATA;
    end else if (ce) begin
      case (half)
        HALF_LOW: begin
          out_valid <= in_valid;
          if (in_valid && ser_en) begin
            out_data <= lo_part;
            upper    <= hi_part;
            half     <= HALF_HIGH;
          end else if (in_valid) begin
            out_data <= in_data;
          end
        end
        default: begin
          out_valid <= 1'b1;
          out_data  <= upper;
          half      <= HALF_LOW;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);

  sequence s_split_start;
    in_valid && in_ready && ser_en;
  endsequence

  sequence s_two_halves(word_t lo, word_t hi);
    (out_valid && out_data == lo) ##1 (out_valid && out_data == hi);
  endsequence

  // High half is compared two edges after the split, against the word then taken
  chk_ser_lsb_first: assert property (
    s_split_start |=> s_two_halves($past(lo_part), $past(hi_part, 2)))
    else $error("serializer did not send low half then high half");

  chk_ser_no_take: assert property (
    s_split_start |=> !in_ready ##1 in_ready)
    else $error("serializer took a word while a half was pending");

  chk_bypass_whole: assert property (
    in_valid && in_ready && !ser_en |=> out_valid && out_data == $past(in_data))
    else $error("bypassed word not passed whole");

  chk_half_width: assert property (
    (s_split_start and (width_sel == `TX_WSEL_8)) |=> out_data[19:4] == 16'h0000)
    else $error("8-bit low half wider than four bits");

endmodule

/* File: tx_phase_fifo_byte_serializer.sv */
/*
  Transmit channel front end: four-word phase compensation FIFO or single
  register stage, followed by the optional byte serializer.
  Assumes fabric and parallel sides share clk here; words written by fabric
  logic on in_valid, a clock enable that freezes all state, though register mode clears the FIFO pointers and counts even while it is low, synchronous reset.
*/
`timescale 1ns/1ps
`include "tx_fifo_params.svh"

module tx_phase_fifo_byte_serializer
  import tx_fifo_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  // Configuration straps
  input  wire logic       det_mode,
  input  wire logic       ser_en,
  input  wire logic [1:0] width_sel,
  // Fabric or hard block write side
  input  wire logic       in_valid,
  input  wire word_t      in_data,
  // Parallel side toward the encoder
  output logic            tx_valid,
  output word_t           tx_data,
  // Status
  output logic            overflow,
  output logic            underflow
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fifo_mode_t                mode;       // Active mode
  word_t                     mem [`TX_FIFO_DEPTH];  // FIFO storage
  logic [`TX_FIFO_PTR_W-1:0] wr_ptr;     // Write index
  logic [`TX_FIFO_PTR_W-1:0] rd_ptr;     // Read index
  logic [`TX_FIFO_CNT_W-1:0] count;      // Words held
  logic [`TX_FIFO_CNT_W-1:0] count_seen; // Count as seen by read side
  logic                      full;       // No room
  logic                      wr_fire;    // Word stored
  logic                      rd_fire;    // Word taken
  logic                      stage_valid;// Word offered to serializer
  word_t                     stage_data; // That word
  logic                      ser_ready;  // Serializer can take a word
  logic                      started;    // Stream has begun
  logic                      ser_valid;  // Serializer output valid
  word_t                     ser_data;   // Serializer output word

  // Mode follows the strap
  assign mode = det_mode ? MODE_REG : MODE_FIFO;

  // ----------------------------------------------------------------
  // FIFO control
  // ----------------------------------------------------------------
  assign full    = (count == `TX_FIFO_CNT_W'(`TX_FIFO_DEPTH));
  assign wr_fire = (mode == MODE_FIFO) && in_valid && (!full || rd_fire);
  // Read only what the read side has seen for a cycle and still exists;
  // the stage must be empty or handing its word on at this same edge
  assign rd_fire = (mode == MODE_FIFO) && !(stage_valid && !ser_ready)
                   && (count_seen != `TX_RST_CNT) && (count != `TX_RST_CNT);

  // Storage, one entry per write
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < `TX_FIFO_DEPTH; i++) begin
        mem[i] <= `TX_RST_DATA;
      end
    end else if (ce && wr_fire) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers advance in order
  always_ff @(posedge clk) begin
    if (srst || mode == MODE_REG) begin
      wr_ptr <= `TX_RST_PTR;
      rd_ptr <= `TX_RST_PTR;
    end else if (ce) begin
      if (wr_fire) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (rd_fire) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // Occupancy, and its one-cycle-late copy that sets the latency floor
  always_ff @(posedge clk) begin
    if (srst || mode == MODE_REG) begin
      count      <= `TX_RST_CNT;
      count_seen <= `TX_RST_CNT;
    end else if (ce) begin
      count      <= count + `TX_FIFO_CNT_W'(wr_fire) - `TX_FIFO_CNT_W'(rd_fire);
      count_seen <= count;
    end
  end

  // ----------------------------------------------------------------
  // Stage register feeding the serializer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      stage_valid <= 1'b0;
      stage_data  <= `TX_RST_DATA;
    end else if (ce) begin
      if (mode == MODE_REG) begin
        stage_valid <= in_valid;
        stage_data  <= in_data;
      end else if (rd_fire) begin
        stage_valid <= 1'b1;
        stage_data  <= mem[rd_ptr];
      end else if (ser_ready) begin
        stage_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte serializer
  // ----------------------------------------------------------------
  byte_splitter u_split (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .ser_en    (ser_en),
    .width_sel (width_sel),
    .in_valid  (stage_valid),
    .in_data   (stage_data),
    .in_ready  (ser_ready),
    .out_valid (ser_valid),
    .out_data  (ser_data)
  );

  // Output register toward the encoder
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_valid <= 1'b0;
      tx_data  <= `TX_RST_DATA;
    end else if (ce) begin
      tx_valid <= ser_valid;
      tx_data  <= ser_data;
    end
  end

  // ----------------------------------------------------------------
  // Status flags, sticky until reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      overflow  <= 1'b0;
      underflow <= 1'b0;
      started   <= 1'b0;
    end else if (ce) begin
      if (rd_fire) begin
        started <= 1'b1;
      end
      if (mode == MODE_FIFO && in_valid && !wr_fire) begin
        overflow <= 1'b1;
      end
      if (mode == MODE_FIFO && started && ser_ready && count == `TX_RST_CNT) begin
        underflow <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);

  chk_fifo_depth_bound: assert property (
    count <= `TX_FIFO_CNT_W'(`TX_FIFO_DEPTH))
    else $error("FIFO holds more than four words");

  chk_fifo_min_latency: assert property (
    rd_fire |-> $past(count) != `TX_RST_CNT)
    else $error("word read before one cycle of residence");

  chk_reg_one_cycle: assert property (
    mode == MODE_REG && in_valid |=> stage_valid && stage_data == $past(in_data))
    else $error("register mode did not add exactly one cycle");

  chk_read_order: assert property (
    rd_fire |=> stage_data == $past(mem[rd_ptr]) && rd_ptr == $past(rd_ptr) + 2'h1)
    else $error("FIFO read out of order");

  chk_overflow_flag: assert property (
    mode == MODE_FIFO && in_valid && full && !rd_fire |=> overflow)
    else $error("dropped write did not raise overflow");

  chk_write_store: assert property (
    wr_fire |=> mem[$past(wr_ptr)] == $past(in_data))
    else $error("accepted word not stored at write index");

  chk_stage_hold: assert property (
    mode == MODE_FIFO && stage_valid && !ser_ready |=> stage_valid && $stable(stage_data))
    else $error("stage word lost while serializer busy");

  chk_tx_follows_ser: assert property (
    ser_valid |=> tx_valid && tx_data == $past(ser_data))
    else $error("output register did not follow serializer");

  chk_underflow_flag: assert property (
    mode == MODE_FIFO && started && ser_ready && count == `TX_RST_CNT |=> underflow)
    else $error("empty FIFO did not raise underflow");

  chk_reg_mode_empty: assert property (
    mode == MODE_REG |=> count == `TX_RST_CNT)
    else $error("FIFO occupancy kept in register mode");

endmodule

/* File: fabric_src.sv */
/*
  Fabric-side writer model: presents one word per cycle, or one every two
  cycles while the serializer splits words; burst breaks that pacing.
  Assumes the bench supplies the next word on data_in at each falling edge.
*/
`timescale 1ns/1ps

module fabric_src
  import tx_fifo_pkg::*;
(
  // Clock and pacing control
  input  wire logic  clk,
  input  wire logic  run,
  input  wire logic  burst,
  input  wire logic  ser_en,
  input  wire word_t data_in,
  // Write side toward the block
  output logic       in_valid,
  output word_t      in_data
);
  // ----------------------------------------------------------------
  // Write pacing
  // ----------------------------------------------------------------
  logic skip;  // Idle slot marker while serializer works

  initial begin
    in_valid = 1'b0;
    in_data  = '0;
    skip     = 1'b0;
  end

  // Drive after falling edge, hold across the sampling edge
  always @(negedge clk) begin
    if (run && (burst || !ser_en || !skip)) begin
      in_valid <= 1'b1;
      in_data  <= data_in;
    end else begin
      in_valid <= 1'b0;
      in_data  <= ~in_data;  // Stale data never looks valid
    end
    skip <= run & ser_en & ~skip;
  end
endmodule

/* File: tb_top.sv */
/*
  Self-checking bench for the transmit FIFO and byte serializer: all
  configurations with random words, reset values, drain, overflow.
  Assumes the design package and parameter header are compiled first.
*/
`timescale 1ns/1ps
`include "tx_fifo_params.svh"

module tb_top
  import tx_fifo_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk, srst, ce, det_mode, ser_en, run, burst, sb_on, half;
  logic [1:0] width_sel;
  logic       in_valid, tx_valid, overflow, underflow;
  word_t      in_data, tx_data, data_in;
  word_t      q_data[$];  // Words written, oldest first
  int         q_cyc[$];   // Write edge of each word
  int         cyc, errors, checked, cfg, n;
  logic [31:0] seed = 32'h00000022;  // Xorshift state, set before any clock edge

  tx_phase_fifo_byte_serializer i_tx_phase_fifo_byte_serializer (
    .clk(clk), .srst(srst), .ce(ce), .det_mode(det_mode), .ser_en(ser_en),
    .width_sel(width_sel), .in_valid(in_valid), .in_data(in_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .overflow(overflow), .underflow(underflow));

  fabric_src i_fabric_src (
    .clk(clk), .run(run), .burst(burst), .ser_en(ser_en), .data_in(data_in),
    .in_valid(in_valid), .in_data(in_data));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expected word or half, right aligned
  function automatic word_t expect_word(word_t d, logic [1:0] ws, logic se, logic hi);
    int    w;
    w = (ws == `TX_WSEL_8) ? 8 : (ws == `TX_WSEL_10) ? 10 : (ws == `TX_WSEL_16) ? 16 : 20;
    if (se) begin
      w = w / 2;
      if (hi) d = d >> w;
    end
    return d & ((20'h00001 << w) - 20'h00001);
  endfunction

  function automatic logic [31:0] xorshift(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, random data, scoreboard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // New random word each cycle, trimmed to the channel width
  always @(negedge clk) begin
    seed = xorshift(seed);
    data_in <= expect_word(seed[19:0], width_sel, 1'b0, 1'b0);
  end

  // Record every word the design takes
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (sb_on && !srst && in_valid) begin
      q_data.push_back(in_data);
      q_cyc.push_back(cyc);
    end
  end

  // Compare each output word or half against the oldest written word
  always @(negedge clk) begin
    if (sb_on && tx_valid === 1'b1) begin
      if (q_data.size() == 0) begin
        check("spurious tx_valid", {19'h0, tx_valid}, 20'h00000);
      end else begin
        check("latency", 20'(cyc - q_cyc[0]), 20'((det_mode ? 2 : 4) + (ser_en & half)));
        check("tx_data", tx_data, expect_word(q_data[0], width_sel, ser_en, half));
        if (!ser_en || half) begin
          void'(q_data.pop_front());
          void'(q_cyc.pop_front());
          half = 1'b0;
        end else half = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  task automatic restart(input logic [3:0] c);
    {det_mode, ser_en, width_sel} = c;
    srst = 1'b1;
    q_data.delete();
    q_cyc.delete();
    half = 1'b0;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    check("reset tx_valid", {19'h0, tx_valid}, 20'h00000);
    check("reset tx_data", tx_data, `TX_RST_DATA);
    check("reset flags", {18'h0, overflow, underflow}, 20'h00000);
  endtask

  initial begin
    {srst, ce, det_mode, ser_en, width_sel, run, burst, sb_on} = 9'h180;
    data_in = '0;
    cyc = 0;
    errors = 0;
    checked = 0;
    for (cfg = 0; cfg < 16; cfg++) begin
      restart(cfg[3:0]);
      sb_on = 1'b1;
      run = 1'b1;
      repeat (40) @(negedge clk);
      check("overflow steady", {19'h0, overflow}, 20'h00000);
      if (!det_mode && !ser_en) check("underflow steady", {19'h0, underflow}, 20'h00000);
      run = 1'b0;
      for (n = 0; n < 20 && q_data.size() != 0; n++) @(negedge clk);
      check("words left", 20'(q_data.size()), 20'h00000);
      if (!det_mode && !ser_en) check("underflow drained", {19'h0, underflow}, 20'h00001);
      sb_on = 1'b0;
    end
    // Writes every cycle into a splitting FIFO must overrun four words
    restart(4'h7);
    burst = 1'b1;
    run = 1'b1;
    repeat (12) @(negedge clk);
    check("overflow burst", {19'h0, overflow}, 20'h00001);
    run = 1'b0;
    complete_run();
  end
endmodule
